// file: common/sac_pkg.sv
// Constants, register map and types for the converter control unit.
// Assumes a 100 MHz REF_CLK and an AXI4-Lite register slave.
// ---------------------------------------------------------------------
// How it works
// R1: Input above high reference gives all ones
// R2: Input below low reference gives zero
// R3: Control bits 3:0 pick channel 0..15
// R4: Converter-on bit starts continuous conversions
// R5: Clearing converter-on aborts running conversion
// R6: Done flag low during conversion; here cleared only at start, high-byte read or channel change
// R7: Completion sets done flag, loads result
// R8: Done with interrupt enable raises request; here IRQ also needs bit 0 of the IRQ mask register set
// R9: Reading high byte clears done flag
// R10: Channel change restarts conversion on new channel
// R11: Low byte read freezes results until released
// R12: Software reads low then high byte
// R13: Software reads only high byte for 8 bits
// R14: Divider field 6:5 sets converter clock
// R15: High byte holds 9:2, low byte 1:0
// R16: Wait keeps running, halt disables, then settles
// R17: Registers reset zero, done flag read-only
// R18: Software sets stretch for high-impedance sources
// R19: Fixed conversion length, stretch lengthens sampling
// ---------------------------------------------------------------------
`default_nettype none

package sac_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL = 8'h2e;
  localparam logic [7:0] IDX_RES_HI = 8'h2f;
  localparam logic [7:0] IDX_RES_LO = 8'h30;
  localparam logic [7:0] IDX_CLK_CTRL = 8'h31;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h32;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h33;
  localparam int ADDR_W = 12;
  // Control field positions
  localparam int CTRL_DONE_BIT = 7;
  localparam int CTRL_DIV_LSB = 5;
  localparam int CTRL_ON_BIT = 4;
  localparam int CTRL_CH_LSB = 0;
  // Clock-control field positions
  localparam int CLK_IE_BIT = 0;
  localparam int CLK_STRETCH_BIT = 1;
  // Reset and saturation values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [9:0] RESULT_RST = 10'h000;
  localparam logic [9:0] RESULT_FULL = 10'h3ff;
  localparam logic [9:0] RESULT_ZERO = 10'h000;
  // Timing and AXI response codes
  localparam int CLK_HZ = 100_000_000;
  localparam int ADC_HZ_FAST = 4_000_000;
  localparam int DIV_FAST = CLK_HZ / ADC_HZ_FAST; // Full period, 4 MHz
  localparam int DIV_W = 8;
  localparam int STAB_NS = 1000;
  localparam int STAB_CYC = (STAB_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int SAMPLE_CYC = 3;
  localparam int STRETCH_CYC = 6;
  localparam int CONV_CYC = 10;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;
  // Conversion phases
  typedef enum logic [1:0] {PH_IDLE, PH_SETTLE, PH_SAMPLE, PH_CONVERT} sac_phase_t;
endpackage

`default_nettype wire

// file: core/sac_top.sv
// Converter control unit: registers, clock divider, sequencing, interrupt.
// Assumes an AXI4-Lite master on REF_CLK and a SAR core that returns a
// 10-bit code plus over/under-range levels, synchronised here.
//
// Chosen here: register access over AXI4-Lite.
`default_nettype none

module sac_top
  import sac_pkg::*;
#(
  parameter int SAMPLE_CYCLES = sac_pkg::SAMPLE_CYC,
  parameter int STRETCH_CYCLES = sac_pkg::STRETCH_CYC,
  parameter int CONV_CYCLES = sac_pkg::CONV_CYC,
  parameter int STAB_CYCLES = sac_pkg::STAB_CYC
)(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RESETN,
  // AXI4-Lite write address
  input wire logic [sac_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  // AXI4-Lite write data
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read address
  input wire logic [sac_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  // AXI4-Lite read data
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Low power modes
  input wire logic WAIT_MODE,
  input wire logic HALT_MODE,
  // Analog side
  output logic [3:0] CHANNEL_SEL,
  output logic CONVERTER_POWER,
  output logic SAMPLE_HOLD,
  output logic ADC_CLK,
  input wire logic [9:0] SAR_CODE,
  input wire logic SAR_OVER,
  input wire logic SAR_UNDER,
  // Interrupt
  output logic IRQ,
  output logic WAKE_REQ
);
  import sac_pkg::*;

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic aw_got; // Write address held
    logic w_got; // Write data held
    logic [ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [3:0] chan; // Channel select
    logic [1:0] div_sel; // Clock divider select
    logic conv_on; // Converter on
    logic done; // Conversion done flag
    logic ie; // Done interrupt enable
    logic stretch; // Sample time stretch
    logic [9:0] result;
    logic frozen; // Result lock
    logic irq_stat; // Sticky event
    logic irq_mask;
    sac_phase_t phase;
    logic [DIV_W-1:0] div_cnt; // Prescaler counter
    logic adc_clk;
    logic [15:0] step_cnt; // Converter clock steps or settle cycles
    logic halted; // Halt seen since last settle
    logic [11:0] sync1; // Pin synchroniser first stage
    logic [11:0] sync2;
    logic [1:0] halt_s; // Halt level synchroniser
  } sac_state_t;

  sac_state_t q, d;

  // Divider half-period for a select code; the low half takes any odd cycle
  function automatic logic [DIV_W-1:0] half_period(input logic [1:0] sel, input logic lvl);
    logic [DIV_W-1:0] full;
    case (sel)
      2'b01: full = DIV_W'(DIV_FAST * 2);
      2'b10: full = DIV_W'(DIV_FAST * 4);
      default: full = DIV_W'(DIV_FAST); // Code 11 treated as fastest
    endcase
    half_period = lvl ? (full >> 1) : (full - (full >> 1));
  endfunction

  // Register index from a byte address
  function automatic logic [7:0] reg_idx(input logic [ADDR_W-1:0] a);
    reg_idx = a[9:2];
  endfunction

  // Mapped index check
  function automatic logic mapped(input logic [7:0] i);
    mapped = (i >= IDX_CTRL) && (i <= IDX_IRQ_MASK);
  endfunction

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  always_comb
  begin
    logic do_wr;
    logic do_rd;
    logic [7:0] widx;
    logic [7:0] ridx;
    logic adc_tick;
    logic [9:0] code;
    logic complete;
    logic ch_change;
    logic [31:0] rd;
    do_wr = 1'b0;
    do_rd = 1'b0;
    widx = 8'h00;
    ridx = 8'h00;
    adc_tick = 1'b0;
    code = 10'h000;
    complete = 1'b0;
    ch_change = 1'b0;
    rd = 32'h0000_0000;
    d = q;

    // Two-flop synchronisers for analog pins and halt level
    d.sync1 = {SAR_OVER, SAR_UNDER, SAR_CODE};
    d.sync2 = q.sync1;
    d.halt_s = {q.halt_s[0], HALT_MODE};

    // Write channels: take address and data in either order
    if (S_AXI_AWVALID && !q.aw_got)
    begin
      d.aw_got = 1'b1;
      d.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !q.w_got)
    begin
      d.w_got = 1'b1;
      d.wdata = S_AXI_WDATA;
      d.wstrb = S_AXI_WSTRB;
    end
    if (q.aw_got && q.w_got && !q.bvalid)
    begin
      do_wr = 1'b1;
      widx = reg_idx(q.awaddr);
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = mapped(widx) ? AXI_OKAY : AXI_SLVERR;
    end
    if (q.bvalid && S_AXI_BREADY)
      d.bvalid = 1'b0;

    // Register writes; byte lane 0 carries all fields
    if (do_wr && q.wstrb[0])
    begin
      case (widx)
        IDX_CTRL:
        begin
          // Done flag is read-only [R17]
          d.chan = q.wdata[CTRL_CH_LSB +: 4]; // [R3]
          d.conv_on = q.wdata[CTRL_ON_BIT]; // [R4] [R5]
          d.div_sel = q.wdata[CTRL_DIV_LSB +: 2]; // [R14]
          ch_change = (q.wdata[CTRL_CH_LSB +: 4] != q.chan);
        end
        IDX_CLK_CTRL:
        begin
          d.ie = q.wdata[CLK_IE_BIT];
          d.stretch = q.wdata[CLK_STRETCH_BIT];
        end
        IDX_IRQ_MASK: d.irq_mask = q.wdata[0];
        default: ; // Result and status registers are read-only [R17]
      endcase
    end

    // Read channel
    if (S_AXI_ARVALID && !q.rvalid)
    begin
      do_rd = 1'b1;
      ridx = reg_idx(S_AXI_ARADDR);
      case (ridx)
        IDX_CTRL: rd = {24'h000000, q.done, q.div_sel, q.conv_on, q.chan};
        IDX_RES_HI: rd = {24'h000000, q.result[9:2]}; // [R15]
        IDX_RES_LO: rd = {30'h00000000, q.result[1:0]}; // [R15]
        IDX_CLK_CTRL: rd = {30'h00000000, q.stretch, q.ie};
        IDX_IRQ_STAT: rd = {31'h00000000, q.irq_stat};
        IDX_IRQ_MASK: rd = {31'h00000000, q.irq_mask};
        default: rd = 32'h0000_0000;
      endcase
      d.rvalid = 1'b1;
      d.rdata = rd;
      d.rresp = mapped(ridx) ? AXI_OKAY : AXI_SLVERR;
    end
    if (q.rvalid && S_AXI_RREADY)
      d.rvalid = 1'b0;

    // Converter clock prescaler
    if (q.div_cnt >= half_period(q.div_sel, q.adc_clk) - DIV_W'(1)) // [R14]
    begin
      d.div_cnt = '0;
      d.adc_clk = ~q.adc_clk;
      adc_tick = q.adc_clk; // One tick per full period
    end
    else
      d.div_cnt = q.div_cnt + DIV_W'(1);

    // Conversion sequencer
    if (q.halt_s[1])
      d.halted = 1'b1;
    case (q.phase)
      PH_IDLE:
        if (q.conv_on && !q.halt_s[1])
        begin
          d.phase = q.halted ? PH_SETTLE : PH_SAMPLE;
          d.step_cnt = '0;
        end
      PH_SETTLE:
      begin
        // Stabilisation after halt wake-up [R16]
        d.step_cnt = q.step_cnt + 16'h0001;
        if (q.step_cnt >= 16'(STAB_CYCLES - 1))
        begin
          d.halted = 1'b0;
          d.phase = PH_SAMPLE;
          d.step_cnt = '0;
        end
      end
      PH_SAMPLE:
        if (adc_tick)
        begin
          d.step_cnt = q.step_cnt + 16'h0001;
          // Stretch lengthens sampling [R19]
          if (q.step_cnt >= 16'((q.stretch ? STRETCH_CYCLES : SAMPLE_CYCLES) - 1))
          begin
            d.phase = PH_CONVERT;
            d.step_cnt = '0;
          end
        end
      PH_CONVERT:
        if (adc_tick)
        begin
          d.step_cnt = q.step_cnt + 16'h0001;
          if (q.step_cnt >= 16'(CONV_CYCLES - 1)) // [R19]
          begin
            complete = 1'b1;
            d.phase = PH_SAMPLE; // Back-to-back [R4]
            d.step_cnt = '0;
          end
        end
      default: d.phase = PH_IDLE;
    endcase

    // Done flag low while the first conversion after a start runs; later
    // completions keep it set until the high byte is read or the channel changes [R6]
    if (q.phase == PH_IDLE && d.phase != PH_IDLE)
      d.done = 1'b0;

    // Saturation of out-of-range inputs [R1] [R2]
    if (q.sync2[11])
      code = RESULT_FULL;
    else if (q.sync2[10])
      code = RESULT_ZERO;
    else
      code = q.sync2[9:0];

    // Completion: set done, load result unless frozen [R7] [R11]
    if (complete)
    begin
      d.done = 1'b1;
      d.irq_stat = 1'b1;
      if (!q.frozen)
        d.result = code;
    end

    // Read side effects
    if (do_rd && ridx == IDX_RES_LO)
      d.frozen = 1'b1; // [R11]
    if (do_rd && ridx == IDX_RES_HI)
    begin
      d.frozen = 1'b0; // [R11]
      if (!complete)
        d.done = 1'b0; // [R9]
    end
    if (do_rd && ridx == IDX_IRQ_STAT && !complete)
      d.irq_stat = 1'b0; // Set wins over read clear

    // Abort on power off, halt outside wait mode, or channel change [R5] [R10] [R16]
    if (do_wr && q.wstrb[0] && widx == IDX_CTRL && !q.wdata[CTRL_ON_BIT])
    begin
      d.phase = PH_IDLE;
      d.frozen = 1'b0; // [R11]
    end
    else if (q.halt_s[1] && !WAIT_MODE)
      d.phase = PH_IDLE;
    else if (ch_change && q.phase != PH_IDLE)
    begin
      d.phase = PH_SAMPLE; // [R10]
      d.step_cnt = '0;
      d.done = 1'b0; // New channel has no result yet [R6]
    end
  end

  // ---------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      q <= '0; // All registers zero [R17]
      q.phase <= PH_IDLE;
    end
    else
      q <= d;
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  assign S_AXI_AWREADY = !q.aw_got;
  assign S_AXI_WREADY = !q.w_got;
  assign S_AXI_BVALID = q.bvalid;
  assign S_AXI_BRESP = q.bresp;
  assign S_AXI_ARREADY = !q.rvalid;
  assign S_AXI_RVALID = q.rvalid;
  assign S_AXI_RDATA = q.rdata;
  assign S_AXI_RRESP = q.rresp;
  assign CHANNEL_SEL = q.chan;
  assign CONVERTER_POWER = q.conv_on && !q.halt_s[1];
  assign SAMPLE_HOLD = (q.phase == PH_SAMPLE);
  assign ADC_CLK = q.adc_clk;
  // Interrupt from done event when enabled [R8]
  assign IRQ = q.irq_stat && q.irq_mask && q.ie; // [R8]
  assign WAKE_REQ = IRQ && !q.halt_s[1]; // Wakes from wait, not halt [R8]
endmodule

`default_nettype wire

// file: dv/sac_analog_model.sv
// Far-side stand-in: analog input multiplexer and converter core.
// Assumes the bench sets a base level and the two range flags.
`default_nettype none

module sac_analog_model (
  // Mux and core controls
  input wire logic [3:0] chan,
  input wire logic power,
  // Scene set by the bench
  input wire logic [9:0] base,
  input wire logic over_in,
  input wire logic under_in,
  // Core outputs
  output logic [9:0] code,
  output logic over,
  output logic under
);
  // Channel n reads base plus n; an unpowered core shows garbage
  always_comb code = power ? base + {6'h0, chan} : ~(base + {6'h0, chan});
  // Range flags only while powered
  always_comb over = power & over_in;
  always_comb under = power & under_in;
endmodule

`default_nettype wire

// file: dv/sac_sva.sv
// Port checker for the converter control unit.
// Assumes it is bound into sac_top; one clock domain.
`default_nettype none

module sac_sva
  import sac_pkg::*;
(
  // Clock, reset, read channel
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic [sac_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  // Modes, analog side, interrupt
  input wire logic HALT_MODE,
  input wire logic CONVERTER_POWER,
  input wire logic SAMPLE_HOLD,
  input wire logic ADC_CLK,
  input wire logic IRQ,
  input wire logic WAKE_REQ
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RESETN);
  // Index of the read in flight
  logic [7:0] ar_ix_q;
  always_ff @(posedge REF_CLK or negedge RESETN)
    if (!RESETN) ar_ix_q <= 8'h00;
    else if (S_AXI_ARVALID && S_AXI_ARREADY) ar_ix_q <= S_AXI_ARADDR[9:2];
  property p_halt_off;
    HALT_MODE [*4] |-> !CONVERTER_POWER;
  endproperty
  a_halt_off: assert property (p_halt_off) else $error("powered in halt");
  property p_halt_wake;
    HALT_MODE [*4] |-> !WAKE_REQ;
  endproperty
  a_halt_wake: assert property (p_halt_wake) else $error("wake in halt");
  property p_wake;
    WAKE_REQ |-> IRQ;
  endproperty
  a_wake: assert property (p_wake) else $error("wake without irq");
  property p_off_idle;
    !CONVERTER_POWER [*3] |-> !SAMPLE_HOLD;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("sampling while off");
  property p_on_sample;
    $rose(CONVERTER_POWER) |-> ##[1:200] SAMPLE_HOLD;
  endproperty
  a_on_sample: assert property (p_on_sample) else $error("no sampling");
  property p_clk_half;
    $changed(ADC_CLK) |=> $stable(ADC_CLK) [*8];
  endproperty
  a_clk_half: assert property (p_clk_half) else $error("converter clock fast");
  property p_unmapped;
    S_AXI_RVALID && (ar_ix_q < IDX_CTRL || ar_ix_q > IDX_IRQ_MASK)
      |-> S_AXI_RRESP == AXI_SLVERR && S_AXI_RDATA == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_lo_pad;
    S_AXI_RVALID && ar_ix_q == IDX_RES_LO |-> S_AXI_RDATA[31:2] == 30'h0;
  endproperty
  a_lo_pad: assert property (p_lo_pad) else $error("low byte pad set");
endmodule

bind sac_top sac_sva u_sva (
  .REF_CLK, .RESETN, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY,
  .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .HALT_MODE, .CONVERTER_POWER,
  .SAMPLE_HOLD, .ADC_CLK, .IRQ, .WAKE_REQ
);

`default_nettype wire

// file: dv/tb_top.sv
// Self-checking bench for the converter control unit.
// Assumes sac_top with sac_sva bound and sac_analog_model on the far side.
`default_nettype none
`define CHK(a, b) \
  begin \
    checks++; \
    if ((a) !== (b)) \
    begin \
      bad_count++; \
      $display("[FAIL] %0t got %h want %h", $time, (a), (b)); \
    end \
  end

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import sac_pkg::*;
  logic REF_CLK = 1'h0, RESETN = 1'h0, WAIT_MODE = 1'h0, HALT_MODE = 1'h0;
  logic S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0;
  logic S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0, over_in = 1'h0, under_in = 1'h0;
  logic [ADDR_W-1:0] S_AXI_AWADDR = '0, S_AXI_ARADDR = '0;
  logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA, rq;
  logic [3:0] S_AXI_WSTRB = 4'hf, CHANNEL_SEL, c;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic CONVERTER_POWER, SAMPLE_HOLD, ADC_CLK, SAR_OVER, SAR_UNDER, IRQ, WAKE_REQ;
  logic [9:0] SAR_CODE, base = 10'h0, b, e;
  int checks = 0, bad_count = 0, k, n, seed = 32'hfb17;
  typedef struct packed {logic [31:0] v; logic [31:0] m; logic [1:0] r;} sac_exp_t;
  sac_exp_t exq[$];
  sac_exp_t ex;
  localparam logic [31:0] ALL = 32'hffffffff;

  always #5 REF_CLK = ~REF_CLK;
  sac_top #(.STAB_CYCLES(2)) dut (.*);
  sac_analog_model u_ana (.chan(CHANNEL_SEL), .power(CONVERTER_POWER), .base, .over_in,
    .under_in, .code(SAR_CODE), .over(SAR_OVER), .under(SAR_UNDER));

  // Scoreboard: each response against the oldest note
  always @(posedge REF_CLK)
    if ((S_AXI_RVALID && S_AXI_RREADY) || (S_AXI_BVALID && S_AXI_BREADY))
    begin
      ex = exq.pop_front();
      `CHK(S_AXI_RVALID ? S_AXI_RRESP : S_AXI_BRESP, ex.r)
      `CHK(S_AXI_RDATA & ex.m, ex.v & ex.m)
    end

  task automatic test_done();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic tmo();
    bad_count++;
    $display("[FAIL] %0t wait ran out", $time);
    test_done();
  endtask

  // Write: address and data together, held until taken
  task automatic wr(input logic [7:0] ix, input logic [31:0] d);
    bit ok;
    exq.push_back('{32'h0, 32'h0, AXI_OKAY});
    @(posedge REF_CLK);
    S_AXI_AWADDR <= {2'h0, ix, 2'h0};
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'h1;
    S_AXI_WVALID <= 1'h1;
    S_AXI_BREADY <= 1'h1;
    ok = 0;
    repeat (50)
    begin
      @(posedge REF_CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'h0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'h0;
      if (S_AXI_BVALID)
      begin
        ok = 1;
        break;
      end
    end
    S_AXI_BREADY <= 1'h0;
    if (!ok) tmo();
  endtask

  // Read: notes value under mask and response, data left in rq
  task automatic rd(input logic [7:0] ix, input logic [31:0] v, input logic [31:0] m,
    input logic [1:0] r);
    bit ok;
    exq.push_back('{v, m, r});
    @(posedge REF_CLK);
    S_AXI_ARADDR <= {2'h0, ix, 2'h0};
    S_AXI_ARVALID <= 1'h1;
    S_AXI_RREADY <= 1'h1;
    ok = 0;
    repeat (50)
    begin
      @(posedge REF_CLK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'h0;
      if (S_AXI_RVALID)
      begin
        ok = 1;
        rq = S_AXI_RDATA;
        break;
      end
    end
    S_AXI_RREADY <= 1'h0;
    if (!ok) tmo();
  endtask

  // Clear a stale flag, then poll the done flag
  task automatic wdone();
    int i;
    rd(IDX_RES_HI, 32'h0, 32'h0, AXI_OKAY);
    for (i = 0; i < 400; i++)
    begin
      rd(IDX_CTRL, 32'h0, 32'h0, AXI_OKAY);
      if (rq[CTRL_DONE_BIT] === 1'h1) return;
    end
    tmo();
  endtask

  // Cycles up to the next converter clock rise
  task automatic rise(output int p);
    logic l;
    l = ADC_CLK;
    for (p = 1; p < 300; p++)
    begin
      @(negedge REF_CLK);
      if (ADC_CLK && !l) return;
      l = ADC_CLK;
    end
    tmo();
  endtask

  initial
  begin
    repeat (100000) @(posedge REF_CLK);
    tmo();
  end

  initial
  begin
    repeat (4) @(posedge REF_CLK);
    RESETN <= 1'h1;
    rd(IDX_CTRL, 32'h0, ALL, AXI_OKAY);
    rd(IDX_RES_HI, 32'h0, ALL, AXI_OKAY);
    rd(IDX_RES_LO, 32'h0, ALL, AXI_OKAY);
    rd(8'h10, 32'h0, ALL, AXI_SLVERR);
    wr(IDX_CTRL, 32'h8f);
    rd(IDX_CTRL, 32'h0f, ALL, AXI_OKAY);
    wr(IDX_RES_HI, 32'hff);
    rd(IDX_RES_HI, 32'h0, ALL, AXI_OKAY);
    for (k = 0; k < 16; k++)
    begin
      wr(IDX_CTRL, 32'(k));
      @(negedge REF_CLK);
      `CHK(CHANNEL_SEL, k[3:0])
    end
    $display("test registers done");
    wr(IDX_IRQ_MASK, 32'h1);
    for (k = 0; k < 4; k++)
    begin
      b = 10'($random(seed));
      c = 4'($random(seed));
      base <= b;
      WAIT_MODE <= k[0];
      wr(IDX_CLK_CTRL, {30'h0, k[1], 1'h1});
      wr(IDX_CTRL, {28'h1, c});
      if (k[0])
      begin
        repeat (60) @(posedge REF_CLK);
        c = c + 4'h7;
        wr(IDX_CTRL, {28'h1, c});
      end
      wdone();
      e = b + {6'h0, c};
      rd(IDX_RES_LO, {30'h0, e[1:0]}, ALL, AXI_OKAY);
      rd(IDX_RES_HI, {24'h0, e[9:2]}, ALL, AXI_OKAY);
      rd(IDX_CTRL, 32'h0, 32'h80, AXI_OKAY);
      `CHK(IRQ, 1'h1)
      rd(IDX_IRQ_STAT, 32'h1, 32'h1, AXI_OKAY);
      repeat (2) @(negedge REF_CLK);
      `CHK(IRQ, 1'h0)
      wr(IDX_CTRL, 32'h0);
    end
    $display("test conversions done");
    WAIT_MODE <= 1'h0;
    for (k = 0; k < 2; k++)
    begin
      over_in <= !k[0];
      under_in <= k[0];
      wr(IDX_CTRL, 32'h10);
      wdone();
      rd(IDX_RES_LO, k[0] ? 32'h0 : 32'h3, ALL, AXI_OKAY);
      rd(IDX_RES_HI, k[0] ? 32'h0 : 32'hff, ALL, AXI_OKAY);
      wr(IDX_CTRL, 32'h0);
    end
    over_in <= 1'h0;
    under_in <= 1'h0;
    $display("test range done");
    base <= 10'h155;
    wr(IDX_CTRL, 32'h10);
    wdone();
    rd(IDX_RES_LO, 32'h1, ALL, AXI_OKAY);
    base <= 10'h2aa;
    repeat (900) @(posedge REF_CLK);
    rd(IDX_RES_HI, 32'h55, ALL, AXI_OKAY);
    HALT_MODE <= 1'h1;
    repeat (6) @(negedge REF_CLK);
    `CHK(CONVERTER_POWER, 1'h0)
    @(posedge REF_CLK);
    HALT_MODE <= 1'h0;
    wdone();
    rd(IDX_RES_LO, 32'h2, ALL, AXI_OKAY);
    rd(IDX_RES_HI, 32'haa, ALL, AXI_OKAY);
    wr(IDX_IRQ_MASK, 32'h0);
    wdone();
    `CHK(IRQ, 1'h0)
    $display("test freeze and halt done");
    for (k = 0; k < 4; k++)
    begin
      wr(IDX_CTRL, 32'h0);
      wr(IDX_CTRL, {25'h0, k[1:0], 5'h10});
      repeat (3) rise(n);
      `CHK(n, (k == 3) ? 25 : 25 << k)
    end
    $display("test divider done");
    test_done();
  end
endmodule

`default_nettype wire
